// ### inc/csp_defs.vh
// Offsets, field positions and reset values of the clocked serial port
`ifndef CSP_DEFS_VH
`define CSP_DEFS_VH
`define CSP_OFS_MODE 3'h0
`define CSP_OFS_STAT 3'h1
`define CSP_OFS_DIV 3'h2
`define CSP_OFS_SHIFT 3'h3
`define CSP_OFS_TRIG 3'h4
`define CSP_OFS_BUF 3'h5
`define CSP_OFS_LAST 3'h6
`define CSP_OFS_PTR 3'h7
`define CSP_MODE_PEN 7
`define CSP_MODE_ATE 6
`define CSP_MODE_ATM 5
`define CSP_MODE_MST 4
`define CSP_MODE_TXE 3
`define CSP_MODE_RXE 2
`define CSP_MODE_DIR 1
`define CSP_MODE_MASK 8'hFE
`define CSP_STAT_TSF 0
`define CSP_STAT_CKS 6
`define CSP_TRIG_STA 0
`define CSP_TRIG_STP 1
`define CSP_TRIG_SUS 2
`define CSP_RST_MODE 8'h00
`define CSP_RST_DIV 8'h00
`define CSP_RST_SHIFT 8'h00
`define CSP_RST_DATA 8'h00
`define CSP_BIT_LAST 3'h7
`endif

// ### logic/csp_port.v
// Clocked three-wire serial port, single-byte and automatic modes
`timescale 1ns/1ps
`include "csp_defs.vh"

module csp_port #(
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire resetn,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire cpu_halt,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  output reg so_out,
  output reg so_oe,
  input wire si_in
);

  reg [7:0] serial_mode_reg;
  reg clock_source_select;
  reg [7:0] clock_divisor_reg;
  reg [7:0] serial_shift_reg;
  reg transfer_in_progress;
  reg auto_stop_request;
  reg suspended;
  reg [AW-1:0] auto_idx;
  reg [AW-1:0] auto_last;
  reg [AW-1:0] buf_ptr;
  reg [7:0] abuf [0:DEPTH-1];
  reg [9:0] hcnt;
  reg [2:0] bitcnt;
  wire sck_s2;
  reg sck_s3;
  wire si_s2;
  reg fall_ev;
  reg rise_ev;

  wire port_enable = serial_mode_reg[`CSP_MODE_PEN];
  wire auto_transfer_enable = serial_mode_reg[`CSP_MODE_ATE];
  wire master_select = serial_mode_reg[`CSP_MODE_MST];
  wire transmit_enable = serial_mode_reg[`CSP_MODE_TXE];
  wire receive_enable = serial_mode_reg[`CSP_MODE_RXE];
  wire bit_order_select = serial_mode_reg[`CSP_MODE_DIR];

  // Half period of the master clock; 10 bits hold 256 << 1
  wire [9:0] half =
    ({2'b00, clock_divisor_reg} + 10'h001) << clock_source_select;

  // Halt only freezes automatic transfers; shifting state is held
  wire freeze = auto_transfer_enable & cpu_halt;

  wire rx_bit = si_s2 & receive_enable;
  wire [7:0] shifted = bit_order_select ?
    {rx_bit, serial_shift_reg[7:1]} :
    {serial_shift_reg[6:0], rx_bit};
  wire cur_bit = bit_order_select ?
    serial_shift_reg[0] : serial_shift_reg[7];

  wire done_ev = rise_ev & (bitcnt == `CSP_BIT_LAST);
  wire [AW-1:0] nidx = auto_idx + {{(AW-1){1'b0}}, 1'b1};

  wire wr_mode = wr & (addr == `CSP_OFS_MODE);
  wire wr_stat = wr & (addr == `CSP_OFS_STAT);
  wire wr_div = wr & (addr == `CSP_OFS_DIV);
  wire wr_shift = wr & (addr == `CSP_OFS_SHIFT);
  wire wr_trig = wr & (addr == `CSP_OFS_TRIG);
  wire wr_buf = wr & (addr == `CSP_OFS_BUF);
  wire wr_last = wr & (addr == `CSP_OFS_LAST);
  wire wr_ptr = wr & (addr == `CSP_OFS_PTR);
  wire rd_buf = rd & (addr == `CSP_OFS_BUF);

  // Single byte start: enabled, auto off, idle
  wire start_single = wr_shift & port_enable &
    ~auto_transfer_enable & ~transfer_in_progress;

  // Auto start or resume; a fresh start begins at index zero
  wire start_auto = wr_trig & wdata[`CSP_TRIG_STA] & port_enable &
    auto_transfer_enable & ~transfer_in_progress;
  wire [AW-1:0] start_idx = suspended ? auto_idx : {AW{1'b0}};

  // Pin inputs pass two flops; edge detect reads the second and a third
  // Clock sync idles high so reset makes no false edge
  csp_sync #(
    .INIT(1'b1)
  ) u_sck_sync (
    .clk(clk),
    .resetn(resetn),
    .d(sck_in),
    .q(sck_s2)
  );

  csp_sync #(
    .INIT(1'b0)
  ) u_si_sync (
    .clk(clk),
    .resetn(resetn),
    .d(si_in),
    .q(si_s2)
  );

  // Third flop only delays the synced clock for edge detection
  always @(posedge clk) begin
    if (!resetn) begin
      sck_s3 <= 1'b1;
    end else begin
      sck_s3 <= sck_s2;
    end
  end

  // Shift events: own divider as master, synced edges as slave
  always @* begin
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    if (transfer_in_progress && !freeze) begin
      if (master_select) begin
        if (hcnt == 10'h001) begin
          fall_ev = sck_out;
          rise_ev = ~sck_out;
        end
      end else begin
        fall_ev = sck_s3 & ~sck_s2;
        rise_ev = ~sck_s3 & sck_s2;
      end
    end
  end

  // Buffer for automatic transfers; two write ports by design
  always @(posedge clk) begin
    if (wr_buf) begin
      abuf[buf_ptr] <= wdata;
    end
    if (done_ev && auto_transfer_enable && receive_enable) begin
      abuf[auto_idx] <= shifted;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      serial_mode_reg <= `CSP_RST_MODE;
      clock_source_select <= 1'b0;
      clock_divisor_reg <= `CSP_RST_DIV;
      serial_shift_reg <= `CSP_RST_SHIFT;
      transfer_in_progress <= 1'b0;
      auto_stop_request <= 1'b0;
      suspended <= 1'b0;
      auto_idx <= {AW{1'b0}};
      auto_last <= {AW{1'b0}};
      buf_ptr <= {AW{1'b0}};
      hcnt <= 10'h001;
      bitcnt <= 3'h0;
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
      so_out <= 1'b1;
      so_oe <= 1'b0;
    end else begin
      sck_oe <= port_enable & master_select;
      so_oe <= port_enable & transmit_enable;

      // Master clock generator; idles high between transfers
      if (transfer_in_progress && !freeze && master_select) begin
        if (hcnt == 10'h001) begin
          hcnt <= half;
          sck_out <= ~sck_out;
        end else begin
          hcnt <= hcnt - 10'h001;
        end
      end

      // Data changes on the falling edge, sampled on the rising
      if (fall_ev) begin
        so_out <= transmit_enable ? cur_bit : 1'b1;
      end
      if (rise_ev) begin
        serial_shift_reg <= shifted;
        bitcnt <= bitcnt + 3'h1;
      end

      // Byte boundary: the only place a suspend may take effect
      if (done_ev) begin
        if (!auto_transfer_enable) begin
          transfer_in_progress <= 1'b0;
        end else if (auto_idx == auto_last) begin
          transfer_in_progress <= 1'b0;
          auto_idx <= {AW{1'b0}};
          auto_stop_request <= 1'b0;
        end else if (auto_stop_request) begin
          transfer_in_progress <= 1'b0;
          suspended <= 1'b1;
          auto_stop_request <= 1'b0;
          auto_idx <= nidx;
        end else begin
          auto_idx <= nidx;
          serial_shift_reg <= abuf[nidx];
        end
      end

      // Bus writes; bit 5 is stored but steers nothing
      if (wr_mode) begin
        serial_mode_reg <= wdata & `CSP_MODE_MASK;
      end
      if (wr_stat) begin
        clock_source_select <= wdata[`CSP_STAT_CKS];
      end
      if (wr_div) begin
        clock_divisor_reg <= wdata;
      end
      if (wr_last) begin
        auto_last <= wdata[AW-1:0];
      end
      if (wr_ptr) begin
        buf_ptr <= wdata[AW-1:0];
      end else if (wr_buf || rd_buf) begin
        buf_ptr <= buf_ptr + {{(AW-1){1'b0}}, 1'b1};
      end

      // Set wins over the hardware clear at the byte boundary
      if (wr_trig && wdata[`CSP_TRIG_STP] && auto_transfer_enable &&
          transfer_in_progress) begin
        auto_stop_request <= 1'b1;
      end

      if (start_single) begin
        serial_shift_reg <= wdata;
        transfer_in_progress <= 1'b1;
        bitcnt <= 3'h0;
        hcnt <= half;
        sck_out <= 1'b1;
      end
      if (start_auto) begin
        serial_shift_reg <= abuf[start_idx];
        auto_idx <= start_idx;
        suspended <= 1'b0;
        // A stop left over from a finished run must not cut this one
        auto_stop_request <= 1'b0;
        transfer_in_progress <= 1'b1;
        bitcnt <= 3'h0;
        hcnt <= half;
        sck_out <= 1'b1;
      end

      // Disabling the port aborts everything and parks the clock
      if (!port_enable) begin
        transfer_in_progress <= 1'b0;
        auto_stop_request <= 1'b0;
        suspended <= 1'b0;
        bitcnt <= 3'h0;
        sck_out <= 1'b1;
        hcnt <= 10'h001;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (!resetn) begin
      rdata <= `CSP_RST_DATA;
    end else if (!rd) begin
      rdata <= `CSP_RST_DATA;
    end else begin
      case (addr)
        `CSP_OFS_MODE: begin
          rdata <= serial_mode_reg;
        end
        `CSP_OFS_STAT: begin
          rdata <= `CSP_RST_DATA;
          rdata[`CSP_STAT_CKS] <= clock_source_select;
          rdata[`CSP_STAT_TSF] <= transfer_in_progress;
        end
        `CSP_OFS_DIV: begin
          rdata <= clock_divisor_reg;
        end
        `CSP_OFS_SHIFT: begin
          rdata <= serial_shift_reg;
        end
        `CSP_OFS_TRIG: begin
          rdata <= `CSP_RST_DATA;
          rdata[`CSP_TRIG_STP] <= auto_stop_request;
          rdata[`CSP_TRIG_SUS] <= suspended;
        end
        `CSP_OFS_BUF: begin
          rdata <= {{(8-AW){1'b0}}, {AW{1'b0}}} | abuf[buf_ptr];
        end
        `CSP_OFS_LAST: begin
          rdata <= {{(8-AW){1'b0}}, auto_last};
        end
        `CSP_OFS_PTR: begin
          rdata <= {{(8-AW){1'b0}}, buf_ptr};
        end
        default: begin
          rdata <= `CSP_RST_DATA;
        end
      endcase
    end
  end

endmodule // csp_port

// Two-flop synchroniser for one pin input
module csp_sync #(
  parameter INIT = 1'b0
) (
  input wire clk,
  input wire resetn,
  input wire d,
  output reg q
);

  reg meta;

  // Only q may be read; meta can be metastable
  always @(posedge clk) begin
    if (!resetn) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // csp_sync

// ### verif/csp_port_assertions.sv
// Port-level checker of the clocked serial port
`timescale 1ns/1ps
module csp_port_assertions (
  input wire clk,
  input wire resetn,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire cpu_halt,
  input wire sck_out,
  input wire sck_oe,
  input wire so_out,
  input wire so_oe
);
  reg [7:0] mode_q;
  reg cks_q;
  // Shadow of software writes, so checks need no view inside
  always @(posedge clk) begin
    if (!resetn) begin
      mode_q <= 8'h00;
      cks_q <= 1'b0;
    end else if (wr && addr == 3'h0) begin
      mode_q <= wdata;
    end else if (wr && addr == 3'h1) begin
      cks_q <= wdata[6];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_reset_idle: assert property (disable iff (1'b0) !resetn |=>
    sck_out && !sck_oe && !so_oe && rdata == 8'h00) else $error("not idle");
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("stray read data");
  a_mode_read: assert property (rd && addr == 3'h0 |=>
    rdata == ($past(mode_q) & 8'hFE)) else $error("mode readback");
  a_stat_bits: assert property (rd && addr == 3'h1 |=>
    (rdata & 8'hBE) == 8'h00 && rdata[6] == $past(cks_q))
    else $error("status layout");
  a_clk_drive: assert property (wr && addr == 3'h0 ##1 !wr |=>
    sck_oe == ($past(wdata[7], 2) && $past(wdata[4], 2)))
    else $error("clock enable");
  a_data_drive: assert property (wr && addr == 3'h0 ##1 !wr |=>
    so_oe == ($past(wdata[7], 2) && $past(wdata[3], 2)))
    else $error("data enable");
  a_out_on_fall: assert property (so_oe && $past(so_oe) && sck_oe &&
    $past(sck_oe) && so_out != $past(so_out) |-> $fell(sck_out))
    else $error("data moved off falling clock");
  a_halt_hold: assert property (cpu_halt && $past(cpu_halt) &&
    mode_q[6] && $past(mode_q[6]) && sck_oe |-> $stable(sck_out))
    else $error("clock moved in halt");
endmodule // csp_port_assertions

bind csp_port csp_port_assertions u_chk (.clk(clk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .cpu_halt(cpu_halt), .sck_out(sck_out), .sck_oe(sck_oe),
  .so_out(so_out), .so_oe(so_oe));

// ### verif/csp_peer.sv
// Serial peripheral on the far side of the link
`timescale 1ns/1ps
module csp_peer (
  input wire sck_out,
  input wire sck_oe,
  input wire so_out,
  input wire lsb,
  input wire slow,
  input wire [7:0] tx_byte,
  output wire sck_in,
  output reg si_in,
  output reg [7:0] rx_byte,
  output reg [7:0] frames
);
  reg own = 1'b1;
  reg [7:0] sh = 8'h00;
  reg [2:0] cnt = 3'h0;
  reg line = 1'b1;
  wire [7:0] src = (cnt == 3'h0) ? tx_byte : sh;
  assign sck_in = line;
  // Unknown drive at power-up reads as idle high: no false edge
  always @* line = (sck_oe === 1'b1) ? sck_out : own;
  initial si_in = 1'b1;
  initial frames = 8'h00;
  always @(negedge line) begin // Next bit on falling clock
    si_in <= #(slow ? 60 : 2) (lsb ? src[0] : src[7]);
    sh <= lsb ? src >> 1 : src << 1;
  end
  always @(posedge line) begin // Sample on rising clock
    rx_byte <= lsb ? {so_out, rx_byte[7:1]} : {rx_byte[6:0], so_out};
    cnt <= cnt + 3'h1;
    if (cnt == 3'h7) begin
      frames <= frames + 8'h01;
      si_in <= #40 ~si_in; // Released line must not keep its value
    end
  end
  task run_clock; // Slave clock, only within a frame
    repeat (16) #100 own = ~own;
  endtask
endmodule // csp_peer

// ### verif/csp_port_test.sv
// Self-checking bench of the clocked serial port
`timescale 1ns/1ps
module csp_port_test;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg cpu_halt = 1'b0;
  reg lsb = 1'b0;
  reg slow = 1'b0;
  reg [7:0] tx_byte = 8'h00;
  wire [7:0] rdata, rx_byte, frames;
  wire sck_in, sck_out, sck_oe, so_out, so_oe, si_in;
  integer failures = 0;
  integer tests_run = 0;
  integer i;
  reg [7:0] v;
  reg [18:0] rows [0:4];
  csp_port u_csp_port (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cpu_halt(cpu_halt),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .so_out(so_out),
    .so_oe(so_oe), .si_in(si_in));
  csp_peer u_peer (.sck_out(sck_out), .sck_oe(sck_oe), .so_out(so_out),
    .lsb(lsb), .slow(slow), .tx_byte(tx_byte), .sck_in(sck_in),
    .si_in(si_in), .rx_byte(rx_byte), .frames(frames));
  always #12.5 clk = ~clk;
  task check(input [15:0] seen, input [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr_reg(input [2:0] a, input [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd_reg(input [2:0] a, output [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task wait_idle; // Bounded poll of the busy flag
    int k;
    v = 8'h01;
    for (k = 0; k < 400 && v[0]; k = k + 1) rd_reg(3'h1, v);
    check(v & 8'h01, 8'h00);
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    failures = failures + 1;
    end_of_test;
  end
  initial begin
    rows[0] = {3'h0, 8'hFF, 8'hFE};
    rows[1] = {3'h0, 8'h20, 8'h20};
    rows[2] = {3'h1, 8'hFF, 8'h40};
    rows[3] = {3'h2, 8'hA5, 8'hA5};
    rows[4] = {3'h0, 8'h00, 8'h00};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check({sck_out, sck_oe, so_out, so_oe, rdata}, 12'hA00);
    for (i = 0; i < 5; i = i + 1) begin
      wr_reg(rows[i][18:16], rows[i][15:8]);
      rd_reg(rows[i][18:16], v);
      check(v, rows[i][7:0]);
    end
    wr_reg(3'h1, 8'h40);
    wr_reg(3'h2, 8'h03);
    wr_reg(3'h0, 8'h1C);
    wr_reg(3'h0, 8'h9C);
    tx_byte <= 8'h3C;
    wr_reg(3'h3, 8'hA5);
    wr_reg(3'h3, 8'hFF); // Busy, so dropped
    wait_idle;
    check(rx_byte, 8'hA5);
    rd_reg(3'h3, v);
    check(v, 8'h3C);
    lsb <= 1'b1;
    slow <= 1'b1;
    tx_byte <= 8'h81;
    wr_reg(3'h0, 8'hBE);
    wr_reg(3'h3, 8'h5A);
    wait_idle;
    check(rx_byte, 8'h5A);
    rd_reg(3'h3, v);
    check(v, 8'h81);
    wr_reg(3'h0, 8'h1C);
    wr_reg(3'h3, 8'h77); // Port off
    rd_reg(3'h1, v);
    check(v, 8'h40);
    lsb <= 1'b0;
    tx_byte <= 8'hC3;
    wr_reg(3'h0, 8'h84); // Slave, no divisor setup
    wr_reg(3'h3, 8'h00); // Dummy byte
    #7 u_peer.run_clock;
    @(posedge clk);
    wait_idle;
    rd_reg(3'h3, v);
    check({so_oe, sck_oe, v}, 10'h0C3);
    wr_reg(3'h0, 8'hDC);
    wr_reg(3'h7, 8'h00);
    for (i = 1; i < 5; i = i + 1) wr_reg(3'h5, 8'h11 * i[7:0]);
    wr_reg(3'h6, 8'h03);
    wr_reg(3'h7, 8'h00);
    tx_byte <= 8'h6B;
    slow <= 1'b0;
    wr_reg(3'h4, 8'h01);
    wr_reg(3'h4, 8'h02); // Stop inside first byte
    wait_idle;
    rd_reg(3'h4, v);
    check({u_peer.cnt, frames, v[2]}, 12'h009);
    wr_reg(3'h4, 8'h01);
    repeat (20) @(posedge clk);
    cpu_halt <= 1'b1;
    #1 v = {u_peer.cnt, frames[4:0]};
    repeat (40) @(posedge clk);
    check({u_peer.cnt, frames[4:0]}, v);
    cpu_halt <= 1'b0;
    wait_idle;
    check({frames, rx_byte}, 16'h0744);
    wr_reg(3'h7, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      rd_reg(3'h5, v);
      check(v, 8'h6B);
    end
    wr_reg(3'h0, 8'h9C); // Busy already clear
    rd_reg(3'h1, v);
    check(v, 8'h40);
    end_of_test;
  end
endmodule // csp_port_test
